// File: tb/psr_host.sv
// host model: serial bus master issuing register accesses to the bank
module psr_host
   import psr_pkg::*;
#(
   parameter int WAIT_CYC = 4
)(
   input  wire logic        mclk,
   output psr_acc_s         acc,
   input  wire logic [15:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial acc = '0;

   // one access held up to its taking edge; released lines show the inverse
   task automatic access(input logic r, input logic [7:0] a,
                         input logic [7:0] d, output logic [15:0] q);
      @(posedge mclk);
      acc <= '{rd: r, wr: !r, addr: a, wdata: d};
      @(posedge mclk);
      acc <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      #1;
      q = rdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [15:0] q;
      access(1'b0, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      access(1'b1, a, 8'h00, q);
   endtask

   // waits are shortened to a few cycles, the bank needs no settling time
   task automatic ind_wr(input logic [7:0] p, input logic [7:0] d);
      wr(OFS_POINTER, p);
      wr(OFS_WDATA, d);
      wr(OFS_OPERATION, OP_IND_WRITE);
      repeat (WAIT_CYC) @(posedge mclk);
   endtask

   task automatic ind_rd(input logic [7:0] p, output logic [15:0] q);
      wr(OFS_POINTER, p);
      wr(OFS_OPERATION, OP_IND_READ);
      repeat (WAIT_CYC) @(posedge mclk);
      rd(OFS_LOW_SPI, q);
   endtask
endmodule

// File: tb/testbench.sv
// self-checking testbench of the direct register bank
module testbench
   import psr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk = 0, rst_b = 0, clk_en = 1, spi_variant = 1;
   logic        twowire_sel = 0, meas_valid = 0, nvm_valid = 0;
   psr_acc_s    acc;
   psr_core_s   core = '0;
   logic [15:0] rdata;
   logic [18:0] pressure = '0;
   logic [13:0] temperature = '0;
   logic [7:0]  nvm_byte = '0, operation, indirect_pointer;
   logic [7:0]  lp_resolution, twowire_slave_addr, miso_drive_cfg;
   logic        soft_rst, op_strobe, result_ready;
   int          failures = 0, checked = 0;

   psr_regbank dut (.mclk, .rst_b, .clk_en, .spi_variant, .twowire_sel,
      .acc, .rdata, .core, .meas_valid, .pressure, .temperature,
      .nvm_valid, .nvm_byte, .soft_rst, .operation, .op_strobe,
      .indirect_pointer, .lp_resolution, .twowire_slave_addr,
      .miso_drive_cfg, .result_ready);

   psr_host #(.WAIT_CYC(4)) host (.mclk, .acc, .rdata);

   initial forever #2.5 mclk = ~mclk;

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // status word built from the core levels and the sticky late flag
   function automatic logic [15:0] status_exp(psr_core_s c, logic late);
      return {9'h000, c.ext_ext_trigger_pin_running, c.result_ready, late,
              c.overpressure_flag, 2'b00, c.boot_running};
   endfunction

   // every readable status and result place must be zero after reset
   task automatic zero_regs();
      logic [7:0]  ofs [6] = '{OFS_PROGRESS, OFS_STATUS, OFS_SOFTRST,
                               OFS_HIGH_SPI, OFS_LOW_SPI, OFS_TEMP_SPI};
      logic [15:0] q;
      foreach (ofs[i]) begin
         host.rd(ofs[i], q);
         chk("zero reg", 16'h0000, q);
      end
      chk("lp res", {8'h00, LP_RES_RST}, {8'h00, lp_resolution});
      chk("tw addr", {8'h00, TW_ADDR_RST},
          {8'h00, twowire_slave_addr});
      chk("miso", {8'h00, MISO_RST}, {8'h00, miso_drive_cfg});
   endtask

   task automatic capture(input logic [18:0] p, input logic [13:0] t);
      @(posedge mclk);
      pressure <= p;
      temperature <= t;
      meas_valid <= 1;
      @(posedge mclk);
      meas_valid <= 0;
      pressure <= ~p;
      temperature <= ~t;
   endtask

   initial begin
      #100000;
      failures++;
      report_and_stop();
   end

   initial begin
      logic [15:0] q;
      logic [18:0] p;
      logic [13:0] t;
      logic [7:0]  b;
      logic        tw;
      void'($urandom(32'hB6CD45B3));
      repeat (4) @(posedge mclk);
      rst_b <= 1;
      zero_regs();
      $display("test reset done");
      // random status levels, late event kept low here
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         core <= psr_core_s'(6'($urandom) & 6'h3B);
         host.rd(OFS_STATUS, q);
         chk("status",
             status_exp(core, 1'b0), q);
         host.rd(OFS_PROGRESS, q);
         chk("progress", {15'h0000, core.op_running}, q);
         chk("ready pin", {15'h0000, core.result_ready},
             {15'h0000, result_ready});
      end
      core <= '0;
      $display("test status done");
      // results through both address views, corners first
      for (int i = 0; i < 6; i++) begin
         p = (i == 0) ? 19'h7FFFF : 19'($urandom);
         t = (i == 1) ? 14'h2000 : 14'($urandom);
         tw = i[0];
         twowire_sel <= tw;
         capture(p, t);
         host.rd(tw ? OFS_HIGH_TW : OFS_HIGH_SPI, q);
         chk("high", {13'h0000, p[18:16]}, q);
         host.rd(tw ? OFS_LOW_TW : OFS_LOW_SPI, q);
         chk("low", p[15:0], q);
         host.rd(tw ? OFS_TEMP_TW : OFS_TEMP_SPI, q);
         chk("temp", {2'b00, t}, q);
      end
      twowire_sel <= 0;
      $display("test results done");
      // late flag: set by event, kept by other reads, cleared by low read
      @(posedge mclk);
      core <= '{service_late: 1'b1, default: 1'b0};
      @(posedge mclk);
      core <= '0;
      host.rd(OFS_TEMP_SPI, q);
      host.rd(OFS_STATUS, q);
      chk("late set", status_exp(core, 1'b1), q);
      // event and clearing read in one cycle: the event must win
      fork
         host.rd(OFS_LOW_SPI, q);
         begin
            @(posedge mclk);
            core <= '{service_late: 1'b1, default: 1'b0};
            @(posedge mclk);
            core <= '0;
         end
      join
      host.rd(OFS_STATUS, q);
      chk("late both", status_exp(core, 1'b1), q);
      host.rd(OFS_LOW_SPI, q);
      host.rd(OFS_STATUS, q);
      chk("late clr", status_exp(core, 1'b0), q);
      $display("test late done");
      // indirect space; a direct write at its offset must not reach it
      host.wr(8'h00, LP_RES_15BIT);
      chk("lp direct", {8'h00, LP_RES_RST},
          {8'h00, lp_resolution});
      host.ind_wr(IND_LP_RES, LP_RES_15BIT);
      chk("lp res", {8'h00, LP_RES_15BIT},
          {8'h00, lp_resolution});
      chk("op", {8'h00, OP_IND_WRITE}, {8'h00, operation});
      host.ind_rd(IND_LP_RES, q);
      chk("ind rd", {8'h00, LP_RES_15BIT}, q);
      b = 8'($urandom);
      host.ind_wr(IND_TW_ADDR, b);
      chk("tw addr", {8'h00, b}, {8'h00, twowire_slave_addr});
      host.ind_rd(IND_TW_ADDR, q);
      chk("tw rd", 16'h0000, q);
      chk("pointer", {8'h00, IND_TW_ADDR},
          {8'h00, indirect_pointer});
      host.rd(OFS_WDATA, q);
      chk("wdata rd", {8'h00, b}, q);
      host.rd(OFS_POINTER, q);
      chk("pointer rd", {8'h00, IND_TW_ADDR}, q);
      @(posedge mclk);
      spi_variant <= 0;
      host.ind_wr(IND_MISO_CFG, MISO_OPEN);
      chk("miso off", {8'h00, MISO_RST}, {8'h00, miso_drive_cfg});
      spi_variant <= 1;
      host.ind_wr(IND_MISO_CFG, MISO_OPEN);
      chk("miso", {8'h00, MISO_OPEN}, {8'h00, miso_drive_cfg});
      host.ind_rd(IND_MISO_CFG, q);
      chk("miso rd", {8'h00, MISO_OPEN}, q);
      $display("test indirect done");
      // memory byte replaces the top bits until the next capture
      b = 8'($urandom);
      @(posedge mclk);
      nvm_byte <= b;
      nvm_valid <= 1;
      @(posedge mclk);
      nvm_valid <= 0;
      nvm_byte <= ~b;
      host.wr(OFS_OPERATION, OP_NVM_READ);
      chk("strobe", 16'h0001, {15'h0000, op_strobe});
      host.rd(OFS_HIGH_SPI, q);
      chk("nvm byte", {8'h00, b}, q);
      p = 19'($urandom);
      capture(p, 14'h0000);
      host.rd(OFS_HIGH_SPI, q);
      chk("high back", {13'h0000, p[18:16]}, q);
      // a capture while the clock enable is low must not land
      @(posedge mclk);
      clk_en <= 0;
      capture(~p, 14'h1555);
      @(posedge mclk);
      clk_en <= 1;
      host.rd(OFS_LOW_SPI, q);
      chk("frozen", p[15:0], q);
      $display("test memory done");
      // soft reset: 0x00 does nothing, 0x01 restores all reset values
      host.wr(OFS_SOFTRST, 8'h00);
      chk("no reset", 16'h0000, {15'h0000, soft_rst});
      host.wr(OFS_SOFTRST, RST_DO);
      chk("reset", 16'h0001, {15'h0000, soft_rst});
      repeat (2) @(posedge mclk);
      zero_regs();
      $display("test soft reset done");
      report_and_stop();
   end
endmodule

// File: verilog/psr_indirect.sv
// indirect configuration space behind pointer, data and operation
module psr_indirect
   import psr_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       clk_en,
   input  wire logic       soft_rst,
   input  wire logic       spi_variant,
   input  wire logic       ind_wr,
   input  wire logic       ind_rd,
   input  wire logic [7:0] pointer,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata,
   output logic      [7:0] lp_resolution,
   output logic      [7:0] twowire_slave_addr,
   output logic      [7:0] miso_drive_cfg
);
   // write decode; unknown pointers are dropped
   wire hit_res  = ind_wr && pointer == IND_LP_RES;
   wire hit_tw   = ind_wr && pointer == IND_TW_ADDR;
   wire hit_miso = ind_wr && pointer == IND_MISO_CFG && spi_variant;

   // read mux: the address register is write-only and reads zero
   wire [7:0] sel_rd = (pointer == IND_LP_RES) ? lp_resolution :
                       (pointer == IND_MISO_CFG && spi_variant) ?
                       miso_drive_cfg : 8'h00;

   // configuration storage
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lp_resolution      <= LP_RES_RST;
         twowire_slave_addr <= TW_ADDR_RST;
         miso_drive_cfg     <= MISO_RST;
         rdata              <= 8'h00;
      end else if (clk_en) begin
         if (soft_rst) begin
            lp_resolution      <= LP_RES_RST;
            twowire_slave_addr <= TW_ADDR_RST;
            miso_drive_cfg     <= MISO_RST;
            rdata              <= 8'h00;
         end else begin
            if (hit_res) lp_resolution <= wdata;
            if (hit_tw) twowire_slave_addr <= wdata;
            if (hit_miso) miso_drive_cfg <= wdata;
            if (ind_rd) rdata <= sel_rd;
         end
      end
   end

   lp_write_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && hit_res |=> lp_resolution == $past(wdata))
      else $error("resolution register missed a write");
   miso_gate_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !spi_variant |-> miso_drive_cfg == MISO_RST)
      else $error("drive style changed on non-spi part");
endmodule

// File: verilog/psr_pkg.sv
// package of register offsets, field positions, reset values and carriers
package psr_pkg;
   // direct register offsets, spi view
   localparam logic [7:0] OFS_WDATA     = 8'h01;
   localparam logic [7:0] OFS_POINTER   = 8'h02;
   localparam logic [7:0] OFS_OPERATION = 8'h03;
   localparam logic [7:0] OFS_PROGRESS  = 8'h04;
   localparam logic [7:0] OFS_SOFTRST   = 8'h06;
   localparam logic [7:0] OFS_STATUS    = 8'h07;
   localparam logic [7:0] OFS_HIGH_SPI  = 8'h1F;
   localparam logic [7:0] OFS_LOW_SPI   = 8'h20;
   localparam logic [7:0] OFS_TEMP_SPI  = 8'h21;
   // the two-wire view puts result registers 0x60 higher
   localparam logic [7:0] OFS_HIGH_TW   = 8'h7F;
   localparam logic [7:0] OFS_LOW_TW    = 8'h80;
   localparam logic [7:0] OFS_TEMP_TW   = 8'h81;
   // indirect register offsets
   localparam logic [7:0] IND_LP_RES    = 8'h00;
   localparam logic [7:0] IND_TW_ADDR   = 8'h05;
   localparam logic [7:0] IND_MISO_CFG  = 8'h09;
   // indirect reset and legal values
   localparam logic [7:0] LP_RES_RST    = 8'h05;
   localparam logic [7:0] LP_RES_15BIT  = 8'h0D;
   localparam logic [7:0] TW_ADDR_RST   = 8'h11;
   localparam logic [7:0] MISO_RST      = 8'h13;
   localparam logic [7:0] MISO_OPEN     = 8'h17;
   // operation codes
   localparam logic [7:0] OP_IND_READ   = 8'h01;
   localparam logic [7:0] OP_IND_WRITE  = 8'h02;
   localparam logic [7:0] OP_NVM_READ   = 8'h05;
   // soft reset command values
   localparam logic [7:0] RST_DO        = 8'h01;
   // status field positions
   localparam int ST_BOOT  = 0;
   localparam int ST_OVP   = 3;
   localparam int ST_LATE  = 4;
   localparam int ST_READY = 5;
   localparam int ST_EXT_TRIGGER_PIN  = 6;
   localparam int PROG_BIT = 0;
   // pressure split
   localparam int PRES_W = 19;
   localparam int TEMP_W = 14;

   // one register access on the serial slave port
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } psr_acc_s;

   // status inputs coming from the measurement core
   typedef struct packed {
      logic boot_running;
      logic ext_ext_trigger_pin_running;
      logic result_ready;
      logic service_late;
      logic overpressure_flag;
      logic op_running;
   } psr_core_s;

   // which result the high/low registers currently carry
   typedef enum logic [1:0] {SRC_MEAS, SRC_IND, SRC_NVM} psr_src_e;
endpackage

// File: verilog/psr_regbank.sv
// direct register bank of the barometric sensor slave port
module psr_regbank
   import psr_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                rst_b,
   input  wire logic                clk_en,
   input  wire logic                spi_variant,
   input  wire logic                twowire_sel,
   input  wire psr_acc_s            acc,
   output logic               [15:0] rdata,
   input  wire psr_core_s           core,
   input  wire logic                meas_valid,
   input  wire logic [PRES_W-1:0]   pressure,
   input  wire logic [TEMP_W-1:0]   temperature,
   input  wire logic                nvm_valid,
   input  wire logic          [7:0] nvm_byte,
   output logic                     soft_rst,
   output logic               [7:0] operation,
   output logic                     op_strobe,
   output logic               [7:0] indirect_pointer,
   output logic               [7:0] lp_resolution,
   output logic               [7:0] twowire_slave_addr,
   output logic               [7:0] miso_drive_cfg,
   output logic                     result_ready
);
   // results, the command registers and the selected source
   logic [7:0]        indirect_write_data;
   logic [PRES_W-1:0] pres_hold;
   logic [TEMP_W-1:0] temp_hold;
   logic [7:0]        nvm_hold;
   psr_src_e          high_src;
   psr_src_e          low_src;
   logic              late_err;
   logic [7:0]        ind_rdata;

   // address compare shared by every view
   function automatic logic at(input logic [7:0] a,
                               input logic [7:0] spi_ofs,
                               input logic [7:0] tw_ofs);
      at = twowire_sel ? (a == tw_ofs) : (a == spi_ofs);
   endfunction

   // direct decode; result offsets follow the active link
   wire wr_ptr   = acc.wr && acc.addr == OFS_POINTER;
   wire wr_wdata = acc.wr && acc.addr == OFS_WDATA;
   wire wr_op    = acc.wr && acc.addr == OFS_OPERATION;
   wire wr_rst   = acc.wr && acc.addr == OFS_SOFTRST;
   wire rd_high  = acc.rd && at(acc.addr, OFS_HIGH_SPI, OFS_HIGH_TW);
   wire rd_low   = acc.rd && at(acc.addr, OFS_LOW_SPI, OFS_LOW_TW);
   wire sel_temp = at(acc.addr, OFS_TEMP_SPI, OFS_TEMP_TW);

   // soft reset only on the exact value; 0x00 and reserved codes do nothing
   wire next_soft_rst = wr_rst && acc.wdata == RST_DO;
   wire op_ind_rd = wr_op && acc.wdata == OP_IND_READ;
   wire op_ind_wr = wr_op && acc.wdata == OP_IND_WRITE;
   wire op_nvm_rd = wr_op && acc.wdata == OP_NVM_READ;

   // status byte, reserved bits 7 and 2:1 held at zero
   wire [7:0] status_byte = {1'b0,
                             core.ext_ext_trigger_pin_running,
                             core.result_ready,
                             late_err,
                             core.overpressure_flag,
                             2'b00,
                             core.boot_running};

   // high byte: fetched memory byte, else top pressure bits
   wire [7:0] high_byte = (high_src == SRC_NVM) ? nvm_hold :
                          {5'b00000, pres_hold[PRES_W-1:16]};
   // low word: indirect byte zero-extended, else low pressure bits
   wire [15:0] low_word = (low_src == SRC_IND) ? {8'h00, ind_rdata} :
                          pres_hold[15:0];
   // temperature sign is bit 13; 15:14 read zero
   wire [15:0] temp_word = {2'b00, temp_hold};

   // read mux; unmapped and write-only addresses answer zero
   wire [15:0] next_rdata =
      (acc.addr == OFS_PROGRESS) ? {15'h0000, core.op_running} :
      (acc.addr == OFS_STATUS)   ? {8'h00, status_byte} :
      (acc.addr == OFS_POINTER)  ? {8'h00, indirect_pointer} :
      (acc.addr == OFS_WDATA)    ? {8'h00, indirect_write_data} :
      (acc.addr == OFS_OPERATION)? {8'h00, operation} :
      rd_high                    ? {8'h00, high_byte} :
      rd_low                     ? low_word :
      sel_temp                   ? temp_word : 16'h0000;

   assign result_ready = core.result_ready;

   // command registers and soft reset pulse
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         soft_rst            <= 1'b0;
         operation           <= 8'h00;
         op_strobe           <= 1'b0;
         indirect_pointer    <= 8'h00;
         indirect_write_data <= 8'h00;
      end else if (clk_en) begin
         soft_rst  <= next_soft_rst;
         op_strobe <= wr_op && !soft_rst;
         if (soft_rst) begin
            operation           <= 8'h00;
            indirect_pointer    <= 8'h00;
            indirect_write_data <= 8'h00;
         end else begin
            if (wr_ptr) indirect_pointer <= acc.wdata;
            if (wr_wdata) indirect_write_data <= acc.wdata;
            if (wr_op) operation <= acc.wdata;
         end
      end
   end

   // result holding; a new measurement returns both registers to pressure, but an operation in the same cycle wins
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pres_hold <= '0;
         temp_hold <= '0;
         nvm_hold  <= 8'h00;
         high_src  <= SRC_MEAS;
         low_src   <= SRC_MEAS;
      end else if (clk_en) begin
         if (soft_rst) begin
            pres_hold <= '0;
            temp_hold <= '0;
            nvm_hold  <= 8'h00;
            high_src  <= SRC_MEAS;
            low_src   <= SRC_MEAS;
         end else begin
            if (meas_valid) begin
               pres_hold <= pressure;
               temp_hold <= temperature;
               high_src  <= SRC_MEAS;
               low_src   <= SRC_MEAS;
            end
            if (op_nvm_rd) high_src <= SRC_NVM;
            if (nvm_valid) nvm_hold <= nvm_byte;
            if (op_ind_rd) low_src <= SRC_IND;
         end
      end
   end

   // late-service flag: a new event wins over the clearing read
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         late_err <= 1'b0;
      end else if (clk_en) begin
         if (soft_rst) late_err <= 1'b0;
         else if (core.service_late) late_err <= 1'b1;
         else if (rd_low) late_err <= 1'b0;
      end
   end

   // registered read data, one cycle after the access
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) rdata <= 16'h0000;
      else if (clk_en) rdata <= soft_rst ? 16'h0000 : next_rdata;
   end

   // indirect space; the pointer and data only reach it by operation
   psr_indirect u_ind (
      .mclk               (mclk),
      .rst_b              (rst_b),
      .clk_en             (clk_en),
      .soft_rst           (soft_rst),
      .spi_variant        (spi_variant),
      .ind_wr             (op_ind_wr && !soft_rst),
      .ind_rd             (op_ind_rd && !soft_rst),
      .pointer            (indirect_pointer),
      .wdata              (indirect_write_data),
      .rdata              (ind_rdata),
      .lp_resolution      (lp_resolution),
      .twowire_slave_addr (twowire_slave_addr),
      .miso_drive_cfg     (miso_drive_cfg)
   );

   // read path: each register answers one cycle after its address
   progress_rd_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && acc.addr == OFS_PROGRESS
      |=> rdata == {15'h0000, $past(core.op_running)})
      else $error("progress flag read wrong");
   status_rd_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && acc.addr == OFS_STATUS
      |=> rdata == {8'h00, $past(status_byte)})
      else $error("status read wrong");
   high_rd_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && rd_high
      |=> rdata == {8'h00, $past(high_byte)})
      else $error("high byte read wrong");
   low_rd_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && rd_low
      |=> rdata == $past(low_word))
      else $error("low word read wrong");
   temp_read_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && acc.rd && sel_temp
      |=> rdata[15:14] == 2'b00)
      else $error("temperature unused bits set");

   // soft reset: only the exact command value pulses the reset
   soft_reset_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && wr_rst && acc.wdata == RST_DO |=> soft_rst)
      else $error("soft reset not issued");
   no_reset_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !(wr_rst && acc.wdata == RST_DO) |=> !soft_rst)
      else $error("spurious soft reset");
   reset_clear_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && soft_rst
      |=> pres_hold == '0 && temp_hold == '0 && !late_err
          && rdata == 16'h0000 && high_src == SRC_MEAS)
      else $error("soft reset left results behind");

   // status bits follow the core levels; the late flag is sticky
   status_bits_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      status_byte[ST_READY] == result_ready
      && status_byte[ST_EXT_TRIGGER_PIN] == core.ext_ext_trigger_pin_running
      && status_byte[ST_OVP] == core.overpressure_flag
      && status_byte[ST_BOOT] == core.boot_running)
      else $error("status bits disagree with core");
   late_clear_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && rd_low && !core.service_late |=> !late_err)
      else $error("late flag survived low read");
   late_set_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && core.service_late |=> late_err)
      else $error("late event lost");
   late_hold_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && late_err && !rd_low |=> late_err)
      else $error("late flag dropped without low read");

   // results: capture, source switching and field layout
   capture_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && meas_valid
      |=> pres_hold == $past(pressure)
          && temp_hold == $past(temperature))
      else $error("measurement not captured");
   nvm_src_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && op_nvm_rd |=> high_src == SRC_NVM)
      else $error("memory read did not switch high byte");
   ind_src_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && op_ind_rd |=> low_src == SRC_IND)
      else $error("indirect read did not switch low word");
   high_split_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      high_src != SRC_NVM |-> high_byte[7:3] == 5'b00000)
      else $error("high byte reserved bits set");
   low_ind_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && op_ind_rd && !meas_valid
      |=> low_word[15:8] == 8'h00)
      else $error("indirect read upper byte not zero");

   // command registers take the written byte at the access edge
   ptr_write_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && wr_ptr
      |=> indirect_pointer == $past(acc.wdata))
      else $error("pointer write lost");
   wdata_write_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && wr_wdata
      |=> indirect_write_data == $past(acc.wdata))
      else $error("write data register lost");
   op_write_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      clk_en && !soft_rst && wr_op
      |=> op_strobe && operation == $past(acc.wdata))
      else $error("operation write lost");

   // a low clock enable must freeze the bank, reads included
   freeze_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !clk_en
      |=> $stable(rdata) && $stable(late_err) && $stable(operation)
          && $stable(pres_hold) && $stable(indirect_pointer))
      else $error("state moved with clock enable low");
endmodule
